// File: include/iwd_pkg.sv
// Contract
// - Eight-stage prescaler feeds 12-bit down counter
// - Start code enables watchdog countdown
// - Counter at zero asserts system reset
// - Reload code loads counter from reload value
// - Unlock code lifts divider/reload write protection
// - Any other code restores write protection
// - Divider codes give 4 to 256
// - Reload value resets to all ones
// - Option bit auto-starts watchdog
// - Debug freeze stops counter while halted
// - Own 40 kHz clock, always running
// - Command register write-only, 16-bit field
// - Status bit1 reload, bit0 divider flag
`default_nettype none
package iwd_pkg;

  localparam int CNT_W = 12;
  localparam int DIV_W = 3;
  localparam int PSC_W = 8;
  localparam int OFS_W = 8;
  localparam int CMD_W = 16;

  localparam logic [OFS_W-1:0] OFS_COMMAND  = 8'h00;
  localparam logic [OFS_W-1:0] OFS_DIVIDER  = 8'h04;
  localparam logic [OFS_W-1:0] OFS_RELOAD   = 8'h08;
  localparam logic [OFS_W-1:0] OFS_STATUS   = 8'h0C;

  localparam logic [CMD_W-1:0] CMD_UNLOCK = 16'h5555;
  localparam logic [CMD_W-1:0] CMD_START  = 16'hCCCC;
  localparam logic [CMD_W-1:0] CMD_RELOAD = 16'hAAAA;

  localparam logic [CNT_W-1:0] RELOAD_RST = 12'hFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 12'h000;
  localparam logic [DIV_W-1:0] DIV_RST    = 3'h0;
  localparam logic [DIV_W-1:0] DIV_SEL_MAX = 3'h6;
  localparam logic [PSC_W:0]   PSC_BASE   = 9'h004;

  localparam int STAT_DIV_BIT    = 0;
  localparam int STAT_RELOAD_BIT = 1;

  localparam int CLK_KHZ = 100_000;
  localparam int OSC_KHZ = 40;
  localparam int OSC_DIV = CLK_KHZ / OSC_KHZ;
  localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_DIV - 1);

  // Slow ticks an update needs to reach the counting side
  localparam logic [1:0] SYNC_TICKS = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage : iwd_pkg
`default_nettype wire

// File: hw/iwd_osc_tick.sv
`default_nettype none
module iwd_osc_tick
  import iwd_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } iwd_osc_type;

  iwd_osc_type s_q;
  iwd_osc_type s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = (s_q.cnt == OSC_LAST);
    s_d.cnt  = s_d.tick ? CNT_ZERO : s_q.cnt + 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule : iwd_osc_tick
`default_nettype wire

// File: hw/iwd_prescaler.sv
`default_nettype none
module iwd_prescaler
  import iwd_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_tick,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_divider_select,
  output logic                  o_step
);

  typedef struct packed {
    logic [PSC_W-1:0] cnt;
    logic             step;
  } iwd_psc_type;

  iwd_psc_type s_q;
  iwd_psc_type s_d;

  function automatic logic [PSC_W-1:0] div_last(input logic [DIV_W-1:0] sel);
    logic [PSC_W:0] full;
    full = PSC_BASE << ((sel > DIV_SEL_MAX) ? DIV_SEL_MAX : sel);
    return PSC_W'(full - 1'b1);
  endfunction : div_last

  always_comb begin
    s_d      = s_q;
    s_d.step = 1'b0;
    if (i_tick && i_run) begin
      if (s_q.cnt >= div_last(i_divider_select)) begin
        s_d.cnt  = '0;
        s_d.step = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_step = s_q.step;

endmodule : iwd_prescaler
`default_nettype wire

// File: hw/iwd_top.sv
`default_nettype none
module iwd_top
  import iwd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  wire logic        i_hw_autostart,
  input  wire logic        i_debug_halt,
  input  wire logic        i_debug_halt_freeze,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_wdog_reset,
  output logic             o_wdog_active
);

  typedef struct packed {
    logic                  data_ph;
    logic                  bus_wr;
    logic [OFS_W-1:0]      bus_ofs;
    logic [31:0]           hrdata;
    logic                  hready;
    logic                  hresp;
    logic                  enabled;
    logic                  unlocked;
    logic                  sys_reset;
    logic [DIV_W-1:0]      div_bus;
    logic [DIV_W-1:0]      div_act;
    logic [CNT_W-1:0]      rld_bus;
    logic [CNT_W-1:0]      rld_act;
    logic [1:0]            pend;
    logic [1:0][1:0]       pend_cnt;
    logic [CNT_W-1:0]      count;
  } iwd_state_type;

  localparam iwd_state_type STATE_RST = '{
    data_ph:   1'h0,
    bus_wr:    1'h0,
    bus_ofs:   OFS_COMMAND,
    hrdata:    32'h0000_0000,
    hready:    1'h1,
    hresp:     HRESP_OKAY,
    enabled:   1'h0,
    unlocked:  1'h0,
    sys_reset: 1'h0,
    div_bus:   DIV_RST,
    div_act:   DIV_RST,
    rld_bus:   RELOAD_RST,
    rld_act:   RELOAD_RST,
    pend:      2'h0,
    pend_cnt:  4'h0,
    count:     RELOAD_RST
  };

  iwd_state_type s_q;
  iwd_state_type s_d;

  logic tick;
  logic step;
  logic run;

  // Slow oscillator stand-in; nothing gates it, so it keeps going in any
  // power mode the rest of the chip may enter.
  iwd_osc_tick u_osc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  assign run = s_q.enabled && !(i_debug_halt_freeze && i_debug_halt);

  iwd_prescaler u_psc (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_tick           (tick),
    .i_run            (run),
    .i_divider_select (s_q.div_act),
    .o_step           (step)
  );

  // Read value for the current data phase
  function automatic logic [31:0] read_word(input iwd_state_type s);
    logic [31:0] w;
    w = '0;
    case (s.bus_ofs)
      OFS_COMMAND: w = '0;
      OFS_DIVIDER: w = 32'(s.div_act);
      OFS_RELOAD:  w = 32'(s.rld_act);
      OFS_STATUS: begin
        w[STAT_DIV_BIT]    = s.pend[STAT_DIV_BIT];
        w[STAT_RELOAD_BIT] = s.pend[STAT_RELOAD_BIT];
      end
      default:     w = '0;
    endcase
    return w;
  endfunction : read_word

  always_comb begin
    logic             wr_stb;
    logic [CMD_W-1:0] cmd;
    logic [1:0]       done;
    wr_stb = 1'b0;
    cmd    = i_hwdata[CMD_W-1:0];
    done   = 2'b00;
    s_d    = s_q;

    // Bus slave: one wait state in every data phase
    if (s_q.data_ph) begin
      s_d.data_ph = 1'b0;
      s_d.hready  = 1'b1;
      if (s_q.bus_wr) begin
        wr_stb = 1'b1;
      end else begin
        s_d.hrdata = read_word(s_q);
      end
    end else if (i_hsel && (i_htrans == HTRANS_NONSEQ) && i_hready) begin
      s_d.data_ph = 1'b1;
      s_d.hready  = 1'b0;
      s_d.bus_wr  = i_hwrite;
      s_d.bus_ofs = i_haddr[OFS_W-1:0];
    end

    // Updates reach the counting side after a few slow ticks
    for (int i = 0; i < 2; i++) begin
      if (tick && s_q.pend[i]) begin
        if (s_q.pend_cnt[i] <= 2'h1) begin
          s_d.pend[i]     = 1'b0;
          s_d.pend_cnt[i] = 2'h0;
          done[i]         = 1'b1;
        end else begin
          s_d.pend_cnt[i] = s_q.pend_cnt[i] - 1'b1;
        end
      end
    end
    if (done[STAT_DIV_BIT]) begin
      s_d.div_act = s_q.div_bus;
    end
    if (done[STAT_RELOAD_BIT]) begin
      s_d.rld_act = s_q.rld_bus;
    end

    if (step && (s_q.count != CNT_ZERO)) begin
      s_d.count = s_q.count - 1'b1;
    end

    if (i_hw_autostart) begin
      s_d.enabled = 1'b1;
    end

    if (wr_stb) begin
      case (s_q.bus_ofs)
        OFS_COMMAND: begin
          s_d.unlocked = (cmd == CMD_UNLOCK);
          if (cmd == CMD_START) begin
            s_d.enabled = 1'b1;
          end
          if (cmd == CMD_RELOAD) begin
            s_d.count = s_q.rld_act;
          end
        end
        OFS_DIVIDER: begin
          if (s_q.unlocked) begin
            s_d.div_bus = i_hwdata[DIV_W-1:0];
            s_d.pend[STAT_DIV_BIT]     = 1'b1;
            s_d.pend_cnt[STAT_DIV_BIT] = SYNC_TICKS;
          end
        end
        OFS_RELOAD: begin
          if (s_q.unlocked) begin
            s_d.rld_bus = i_hwdata[CNT_W-1:0];
            s_d.pend[STAT_RELOAD_BIT]     = 1'b1;
            s_d.pend_cnt[STAT_RELOAD_BIT] = SYNC_TICKS;
          end
        end
        default: begin
          s_d.unlocked = s_q.unlocked;
        end
      endcase
    end

    if (s_q.enabled && (s_q.count == CNT_ZERO)) begin
      s_d.sys_reset = 1'b1;
    end
    s_d.hresp = HRESP_OKAY;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_hrdata      = s_q.hrdata;
  assign o_hreadyout   = s_q.hready;
  assign o_hresp       = s_q.hresp;
  assign o_wdog_reset  = s_q.sys_reset;
  assign o_wdog_active = s_q.enabled;

endmodule : iwd_top
`default_nettype wire

// File: dv/iwd_monitor.sv
`default_nettype none
module iwd_monitor
  import iwd_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        i_hw_autostart,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_wdog_reset,
  input wire logic        o_wdog_active
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic take;
  logic cmd_wr_q;
  logic cmd_rd_q;
  assign take = i_hsel && i_htrans == HTRANS_NONSEQ && i_hready;

  // Command access remembered into its data phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmd_wr_q <= 1'b0;
      cmd_rd_q <= 1'b0;
    end else begin
      cmd_wr_q <= take && i_hwrite && i_haddr[7:0] == OFS_COMMAND;
      cmd_rd_q <= take && !i_hwrite && i_haddr[7:0] == OFS_COMMAND;
    end
  end

  sequence s_one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  AST_ONE_WAIT: assert property (take |=> s_one_wait)
    else $error("transfer without exactly one wait state");
  AST_READY_QUIET: assert property (o_hreadyout && !take |=> o_hreadyout)
    else $error("hreadyout dropped with no transfer");
  AST_OKAY: assert property (o_hresp == HRESP_OKAY)
    else $error("response other than okay");
  AST_CMD_READS_ZERO: assert property (cmd_rd_q |=> o_hrdata == 32'h0)
    else $error("command register read not zero");
  AST_START: assert property (cmd_wr_q && i_hwdata[15:0] == CMD_START |-> ##[1:2] o_wdog_active)
    else $error("start code did not enable");
  AST_ACTIVE_HOLDS: assert property (o_wdog_active |=> o_wdog_active)
    else $error("watchdog disabled itself");
  AST_AUTOSTART: assert property (i_hw_autostart |-> ##2 o_wdog_active)
    else $error("option bit did not start watchdog");
  AST_RESET_HOLDS: assert property ($rose(o_wdog_reset) |-> o_wdog_reset [*8])
    else $error("system reset request not held");
  AST_RESET_NEEDS_ACTIVE: assert property (o_wdog_reset |-> o_wdog_active)
    else $error("reset request while disabled");
endmodule : iwd_monitor
`default_nettype wire

// File: dv/testbench.sv
`default_nettype none
module testbench import iwd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        auto = 1'b0, halt = 1'b0, frz = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata, seed = 32'h2076;
  logic        hready, hresp, wrst, wact;
  int          err_count = 0, checks_done = 0;

  iwd_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .i_hw_autostart(auto), .i_debug_halt(halt),
    .i_debug_halt_freeze(frz), .o_hrdata(rdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_wdog_reset(wrst), .o_wdog_active(wact));

  initial forever #5 clk = ~clk;

  function automatic logic [31:0] rnd(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd

  // Cycles for reload r to run out, plus one spare prescaler period and 100 cycles of slack
  function automatic int run_out(input logic [11:0] r, input logic [2:0] c);
    int d;
    d = (c >= 3'h6) ? 256 : (4 << c);
    return (int'(r) + 1) * d * OSC_DIV + 100;
  endfunction : run_out

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, seen);
      err_count++;
    end
  endtask : chk

  // hready is registered, so it is read mid-cycle and acted on at the next edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(negedge clk); while (hready !== 1'b1);
    @(posedge clk);
    // Select dropped with the address phase, so back-to-back calls never
    // assign it twice in one time step
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge clk); while (hready !== 1'b1);
    @(posedge clk);
    r = rdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(n, r, exp);
  endtask : rd

  task automatic settle;
    logic [31:0] r;
    r = 32'h1;
    for (int i = 0; i < 4000 && r !== 32'h0; i++) xfer(1'b0, OFS_STATUS, 32'h0, r);
    chk("status settled", r, 32'h0);
  endtask : settle

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic [11:0] rv;
    logic [2:0]  cv;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd("divider", OFS_DIVIDER, 32'h0);
    rd("reload", OFS_RELOAD, 32'hFFF);
    rd("status", OFS_STATUS, 32'h0);
    rd("command", OFS_COMMAND, 32'h0);
    rd("unmapped", 8'h10, 32'h0);
    wr(OFS_RELOAD, 32'h123);
    rd("locked reload", OFS_RELOAD, 32'hFFF);
    $display("test reset and lock done");
    seed = rnd(seed);
    rv = 12'h1 + {11'h0, seed[0]};
    cv = seed[6:4];
    wr(OFS_COMMAND, {16'h0, CMD_UNLOCK});
    wr(OFS_RELOAD, {20'h0, rv});
    rd("reload pending", OFS_STATUS, 32'h2);
    rd("reload old", OFS_RELOAD, 32'hFFF);
    wr(OFS_DIVIDER, {29'h0, cv});
    rd("both pending", OFS_STATUS, 32'h3);
    rd("divider old", OFS_DIVIDER, 32'h0);
    settle();
    rd("reload new", OFS_RELOAD, {20'h0, rv});
    rd("divider new", OFS_DIVIDER, {29'h0, cv});
    wr(OFS_DIVIDER, 32'h0);
    settle();
    seed = rnd(seed);
    wr(OFS_COMMAND, seed & 32'hFFF);
    wr(OFS_RELOAD, 32'h7);
    rd("relocked", OFS_RELOAD, {20'h0, rv});
    rd("relocked status", OFS_STATUS, 32'h0);
    $display("test protection done");
    halt <= 1'b1;
    frz <= 1'b1;
    wr(OFS_COMMAND, {16'h0, CMD_START});
    wr(OFS_COMMAND, {16'h0, CMD_RELOAD});
    @(negedge clk);
    chk("active", 32'(wact), 32'h1);
    repeat (25000) @(posedge clk);
    @(negedge clk);
    chk("frozen", 32'(wrst), 32'h0);
    @(posedge clk);
    // hold clear, still halted: counts on
    frz <= 1'b0;
    for (int i = 0; i < run_out(rv, 3'h0) && wrst !== 1'b1; i++) @(negedge clk);
    chk("expired", 32'(wrst), 32'h1);
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("reset held", 32'(wrst), 32'h1);
    $display("test countdown done");
    @(posedge clk);
    rst_n <= 1'b0;
    auto <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("autostart", 32'(wact), 32'h1);
    chk("reset cleared", 32'(wrst), 32'h0);
    $display("test autostart done");
    tally_and_finish();
  end
endmodule : testbench

bind iwd_top iwd_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .i_hw_autostart(i_hw_autostart), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_wdog_reset(o_wdog_reset),
  .o_wdog_active(o_wdog_active));
`default_nettype wire
